// *** dcc_config.sv ***
`timescale 1ns/1ps
`include "dcc_regs.svh"
module dcc_config (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Special function register bus
	input wire logic [3:0] sfr_page,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// Converter status and control inputs
	input wire logic conv_sync_enable,
	input wire logic conv_enable,
	input wire logic sleep_mode,
	input wire logic local_osc_tick,
	input wire logic bypass_active,
	// Converter mode outputs
	output logic low_power_enable,
	output logic peak_current_threshold,
	output logic rail_to_battery,
	output logic rail_floating,
	output logic bypass_auto,
	output logic bypass_force,
	output logic conv_osc_stop,
	output logic passive_diode_enable,
	// Converter clock outputs
	output logic conv_clk_tick,
	output logic conv_clk_on_fall,
	// Sampling clock outputs
	output logic adc_sample_clk,
	output logic adc_track_enable
);

	dcc_pkg::dcc_top_st_t st_r;
	dcc_pkg::dcc_top_st_t st_nxt;
	logic cfg_wr;
	logic mode_wr;
	logic cfg_rd;
	logic mode_rd;

	dcc_clk_if cif ();

	////////////////////////////////////////////////////////////////////////////
	// Register decode
	function automatic logic dcc_hit(input logic [3:0] pg, input logic [7:0] ad,
		input logic [3:0] want_pg, input logic [7:0] want_ad);
		dcc_hit = (pg == want_pg) && (ad == want_ad);
	endfunction

	assign cfg_wr = sfr_wr && dcc_hit(sfr_page, sfr_addr, `DCC_CFG_PAGE, `DCC_CFG_ADDR);
	assign mode_wr = sfr_wr && dcc_hit(sfr_page, sfr_addr, `DCC_MODE_PAGE, `DCC_MODE_ADDR);
	assign cfg_rd = sfr_rd && dcc_hit(sfr_page, sfr_addr, `DCC_CFG_PAGE, `DCC_CFG_ADDR);
	assign mode_rd = sfr_rd && dcc_hit(sfr_page, sfr_addr, `DCC_MODE_PAGE, `DCC_MODE_ADDR);

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_nxt = st_r;
		// Register writes
		if (cfg_wr) begin
			st_nxt.cfg = sfr_wdata;
		end
		if (mode_wr) begin
			st_nxt.byp = dcc_pkg::dcc_byp_t'(sfr_wdata[`DCC_MODE_BYP_HI:`DCC_MODE_BYP_LO]);
			st_nxt.pas = sfr_wdata[`DCC_MODE_PAS];
		end
		// Register reads, unmapped reads as zero
		st_nxt.rdata = 8'h00;
		if (cfg_rd) begin
			st_nxt.rdata = st_r.cfg;
		end else if (mode_rd) begin
			st_nxt.rdata[`DCC_MODE_UNUSED_HI:`DCC_MODE_UNUSED_LO] = 4'h0;
			st_nxt.rdata[`DCC_MODE_FLG] = bypass_active;
			st_nxt.rdata[`DCC_MODE_BYP_HI:`DCC_MODE_BYP_LO] = st_r.byp;
			st_nxt.rdata[`DCC_MODE_PAS] = st_r.pas;
		end
		// Sleep rail connection
		st_nxt.rail_batt = sleep_mode && conv_enable && !st_r.cfg[`DCC_CFG_SLP];
		st_nxt.rail_float = sleep_mode && conv_enable && st_r.cfg[`DCC_CFG_SLP];
		// Bypass decode
		st_nxt.byp_auto = (st_r.byp == dcc_pkg::DCC_BYP_AUTO_RUN)
			|| (st_r.byp == dcc_pkg::DCC_BYP_AUTO_STOP);
		st_nxt.byp_force = (st_r.byp == dcc_pkg::DCC_BYP_FORCE);
		st_nxt.osc_stop = (st_r.byp == dcc_pkg::DCC_BYP_AUTO_STOP) && bypass_active;
		// Sampling clock from converter cycle
		st_nxt.adc_ph = cif.tick ? !st_r.adc_ph : st_r.adc_ph;
		st_nxt.adc_clk = st_nxt.adc_ph
			^ (conv_sync_enable && !st_r.cfg[`DCC_CFG_POL]);
		// Tracking in the quiet half of the cycle
		st_nxt.track = conv_sync_enable && st_nxt.adc_ph;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_r.cfg <= `DCC_CFG_RST;
			st_r.byp <= dcc_pkg::dcc_byp_t'(`DCC_BYP_RST);
			st_r.pas <= `DCC_PAS_RST;
			st_r.rdata <= 8'h00;
			st_r.rail_batt <= 1'b0;
			st_r.rail_float <= 1'b0;
			st_r.byp_auto <= 1'b0;
			st_r.byp_force <= 1'b0;
			st_r.osc_stop <= 1'b0;
			st_r.adc_ph <= 1'b0;
			st_r.adc_clk <= 1'b0;
			st_r.track <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Converter clock generator
	assign cif.src_sel = st_r.cfg[`DCC_CFG_SEL];
	assign cif.div_sel = st_r.cfg[`DCC_CFG_DIV_HI:`DCC_CFG_DIV_LO];
	assign cif.clk_inv = st_r.cfg[`DCC_CFG_INV];

	dcc_clkgen u_clkgen (
		.clk(clk),
		.rstn(rstn),
		.local_osc_tick(local_osc_tick),
		.ifc(cif.gen)
	);

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign sfr_rdata = st_r.rdata;
	assign low_power_enable = st_r.cfg[`DCC_CFG_LOW_POWER];
	assign peak_current_threshold = st_r.cfg[`DCC_CFG_ILIM];
	assign rail_to_battery = st_r.rail_batt;
	assign rail_floating = st_r.rail_float;
	assign bypass_auto = st_r.byp_auto;
	assign bypass_force = st_r.byp_force;
	assign conv_osc_stop = st_r.osc_stop;
	assign passive_diode_enable = st_r.pas;
	assign conv_clk_tick = cif.tick;
	assign conv_clk_on_fall = cif.on_fall;
	assign adc_sample_clk = st_r.adc_clk;
	assign adc_track_enable = st_r.track;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	AST_LOW_POWER_WRITE: assert property (@(posedge clk) disable iff (!rstn)
		cfg_wr |=> (low_power_enable == $past(sfr_wdata[`DCC_CFG_LOW_POWER])))
		else $error("Low power bit not written");
	AST_ILIM_HOLD: assert property (@(posedge clk) disable iff (!rstn)
		!cfg_wr |=> $stable(peak_current_threshold))
		else $error("Current threshold changed without write");
	AST_SLEEP_RAIL: assert property (@(posedge clk) disable iff (!rstn)
		(sleep_mode && conv_enable) |=>
		(rail_to_battery == !$past(st_r.cfg[1])) && (rail_floating == $past(st_r.cfg[1])))
		else $error("Sleep rail connection wrong");
	AST_MODE_UNUSED: assert property (@(posedge clk) disable iff (!rstn)
		mode_rd |=> (sfr_rdata[7:4] == 4'h0))
		else $error("Unused mode bits not zero");
	AST_BYP_FLAG: assert property (@(posedge clk) disable iff (!rstn)
		mode_rd |=> (sfr_rdata[3] == $past(bypass_active)))
		else $error("Bypass indicator wrong");
	AST_BYP_FORCE: assert property (@(posedge clk) disable iff (!rstn)
		(mode_wr && sfr_wdata[2:1] == 2'h3) |=> ##1 (bypass_force && !bypass_auto))
		else $error("Forced bypass not applied");
	AST_PASSIVE_DIODE: assert property (@(posedge clk) disable iff (!rstn)
		mode_wr |=> (passive_diode_enable == $past(sfr_wdata[0])))
		else $error("Passive diode bit not written");
	AST_ADC_POL: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> (adc_sample_clk == (st_r.adc_ph
		^ ($past(conv_sync_enable) && !$past(st_r.cfg[`DCC_CFG_POL])))))
		else $error("Sampling clock polarity wrong");
	AST_TRACK_SYNC: assert property (@(posedge clk) disable iff (!rstn)
		adc_track_enable |-> $past(conv_sync_enable))
		else $error("Tracking without sync");
	AST_CFG_READ: assert property (@(posedge clk) disable iff (!rstn)
		cfg_rd |=> (sfr_rdata == $past(st_r.cfg)))
		else $error("Configuration read data wrong");
	AST_MODE_FIELDS: assert property (@(posedge clk) disable iff (!rstn)
		mode_rd |=> ((sfr_rdata[`DCC_MODE_BYP_HI:`DCC_MODE_BYP_LO] == $past(st_r.byp))
		&& (sfr_rdata[`DCC_MODE_PAS] == $past(st_r.pas))))
		else $error("Mode read fields wrong");
	AST_BYP_AUTO: assert property (@(posedge clk) disable iff (!rstn)
		bypass_auto == (($past(st_r.byp) == dcc_pkg::DCC_BYP_AUTO_RUN)
		|| ($past(st_r.byp) == dcc_pkg::DCC_BYP_AUTO_STOP)))
		else $error("Automatic bypass decode wrong");
	AST_OSC_STOP: assert property (@(posedge clk) disable iff (!rstn)
		conv_osc_stop == (($past(st_r.byp) == dcc_pkg::DCC_BYP_AUTO_STOP) && $past(bypass_active)))
		else $error("Oscillator stop decode wrong");
	AST_RAIL_AWAKE: assert property (@(posedge clk) disable iff (!rstn)
		!(sleep_mode && conv_enable) |=> (!rail_to_battery && !rail_floating))
		else $error("Sleep rail driven while awake");
	AST_SYNC_OFF: assert property (@(posedge clk) disable iff (!rstn)
		!conv_sync_enable |=> ((adc_sample_clk == st_r.adc_ph) && !adc_track_enable))
		else $error("Polarity applied without sync");
	AST_TRACK_PHASE: assert property (@(posedge clk) disable iff (!rstn)
		conv_sync_enable |=> (adc_track_enable == st_r.adc_ph))
		else $error("Tracking not in quiet half");
	AST_PHASE_TICK: assert property (@(posedge clk) disable iff (!rstn)
		cif.tick |=> (st_r.adc_ph != $past(st_r.adc_ph)))
		else $error("Sampling phase missed a converter tick");
	AST_PHASE_HOLD: assert property (@(posedge clk) disable iff (!rstn)
		!cif.tick |=> $stable(st_r.adc_ph))
		else $error("Sampling phase moved without tick");

	COV_CFG_WRITE: cover property (@(posedge clk) disable iff (!rstn)
		cfg_wr ##1 cfg_rd);
	COV_FORCE: cover property (@(posedge clk) disable iff (!rstn)
		bypass_force);
	COV_OSC_STOP: cover property (@(posedge clk) disable iff (!rstn)
		conv_osc_stop);
	COV_TRACK: cover property (@(posedge clk) disable iff (!rstn)
		adc_track_enable ##1 !adc_track_enable);

endmodule

// *** dcc_regs.svh ***
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH

// Register pages and addresses
`define DCC_CFG_PAGE 4'h0
`define DCC_CFG_ADDR 8'h96
`define DCC_MODE_PAGE 4'hf
`define DCC_MODE_ADDR 8'h94

// Reset values
`define DCC_CFG_RST 8'h00
`define DCC_BYP_RST 2'h0
`define DCC_PAS_RST 1'b0

// Configuration register fields
`define DCC_CFG_LOW_POWER 7
`define DCC_CFG_DIV_HI 6
`define DCC_CFG_DIV_LO 5
`define DCC_CFG_POL 4
`define DCC_CFG_INV 3
`define DCC_CFG_ILIM 2
`define DCC_CFG_SLP 1
`define DCC_CFG_SEL 0

// Mode register fields
`define DCC_MODE_UNUSED_HI 7
`define DCC_MODE_UNUSED_LO 4
`define DCC_MODE_FLG 3
`define DCC_MODE_BYP_HI 2
`define DCC_MODE_BYP_LO 1
`define DCC_MODE_PAS 0

`endif

// *** dcc_pkg.sv ***
package dcc_pkg;

	// Bypass select codes
	typedef enum logic [1:0] {
		DCC_BYP_OFF = 2'h0,
		DCC_BYP_AUTO_RUN = 2'h1,
		DCC_BYP_AUTO_STOP = 2'h2,
		DCC_BYP_FORCE = 2'h3
	} dcc_byp_t;

	// Clock generator state
	typedef struct packed {
		logic [2:0] cnt;
		logic [1:0] div;
		logic sel;
		logic inv;
		logic tick;
		logic on_fall;
	} dcc_gen_st_t;

	// Register bank state
	typedef struct packed {
		logic [7:0] cfg;
		dcc_byp_t byp;
		logic pas;
		logic [7:0] rdata;
		logic rail_batt;
		logic rail_float;
		logic byp_auto;
		logic byp_force;
		logic osc_stop;
		logic adc_ph;
		logic adc_clk;
		logic track;
	} dcc_top_st_t;

endpackage

// *** dcc_clk_if.sv ***
`timescale 1ns/1ps
interface dcc_clk_if;
	logic src_sel;
	logic [1:0] div_sel;
	logic clk_inv;
	logic tick;
	logic on_fall;

	modport ctl (
		output src_sel,
		output div_sel,
		output clk_inv,
		input tick,
		input on_fall
	);

	modport gen (
		input src_sel,
		input div_sel,
		input clk_inv,
		output tick,
		output on_fall
	);
endinterface

// *** dcc_clkgen.sv ***
`timescale 1ns/1ps
module dcc_clkgen (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Local oscillator edge
	input wire logic local_osc_tick,
	// Settings in, converter clock out
	dcc_clk_if.gen ifc
);

	dcc_pkg::dcc_gen_st_t st_r;
	dcc_pkg::dcc_gen_st_t st_nxt;
	logic boundary;

	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		// Divider ignored on local oscillator
		boundary = st_r.sel ? (st_r.cnt == 3'((3'h1 << st_r.div) - 3'h1)) : local_osc_tick;
		if (st_r.sel) begin
			st_nxt.cnt = 3'(st_r.cnt + 3'h1);
		end
		// Settings taken only at a period boundary
		if (boundary) begin
			st_nxt.tick = 1'b1;
			st_nxt.cnt = 3'h0;
			st_nxt.sel = ifc.src_sel;
			st_nxt.div = ifc.div_sel;
			st_nxt.inv = ifc.clk_inv;
			st_nxt.on_fall = ifc.clk_inv && ifc.src_sel;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign ifc.tick = st_r.tick;
	assign ifc.on_fall = st_r.on_fall;

	////////////////////////////////////////////////////////////////////////////
	AST_DIV8: assert property (@(posedge clk) disable iff (!rstn)
		(st_r.tick && st_r.sel && st_r.div == 2'h3) |-> ##1 !st_r.tick [*7] ##1 st_r.tick)
		else $error("Divide by 8 period wrong");
	AST_LOCAL_SRC: assert property (@(posedge clk) disable iff (!rstn)
		!st_r.sel |=> (st_r.tick == $past(local_osc_tick)))
		else $error("Local oscillator edge not followed");
	AST_NO_RUNT: assert property (@(posedge clk) disable iff (!rstn)
		($changed(st_r.div) || $changed(st_r.sel) || $changed(st_r.inv)) |-> st_r.tick)
		else $error("Clock setting changed mid period");

endmodule

// *** dcc_config_tb.sv ***
`timescale 1ns/1ps
module dcc_config_tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] sfr_page = 4'h0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_rdata;
	logic conv_sync_enable = 1'b0;
	logic conv_enable = 1'b0;
	logic sleep_mode = 1'b0;
	logic local_osc_tick = 1'b0;
	logic bypass_active = 1'b0;
	logic low_power_enable, peak_current_threshold, rail_to_battery, rail_floating;
	logic bypass_auto, bypass_force, conv_osc_stop, passive_diode_enable;
	logic conv_clk_tick, conv_clk_on_fall, adc_sample_clk, adc_track_enable;
	logic osc_run = 1'b1;
	int osc_cnt = 0;
	int num_errors = 0;
	int check_count = 0;

	dcc_config u_dcc_config (.clk(clk), .rstn(rstn), .sfr_page(sfr_page),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .conv_sync_enable(conv_sync_enable),
		.conv_enable(conv_enable), .sleep_mode(sleep_mode),
		.local_osc_tick(local_osc_tick), .bypass_active(bypass_active),
		.low_power_enable(low_power_enable), .peak_current_threshold(peak_current_threshold),
		.rail_to_battery(rail_to_battery), .rail_floating(rail_floating),
		.bypass_auto(bypass_auto), .bypass_force(bypass_force),
		.conv_osc_stop(conv_osc_stop), .passive_diode_enable(passive_diode_enable),
		.conv_clk_tick(conv_clk_tick), .conv_clk_on_fall(conv_clk_on_fall),
		.adc_sample_clk(adc_sample_clk), .adc_track_enable(adc_track_enable));

	////////////////////////////////////////////////////////////////
	// Clock and local oscillator pulses, one every 5 cycles
	always #2 clk = ~clk;
	always @(negedge clk) begin
		osc_cnt <= (osc_cnt == 4) ? 0 : osc_cnt + 1;
		local_osc_tick <= osc_run && (osc_cnt == 0);
	end

	////////////////////////////////////////////////////////////////
	// Tasks and expectation functions
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] pg, input logic [7:0] ad, input logic [7:0] d);
		@(negedge clk);
		sfr_page = pg;
		sfr_addr = ad;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask

	task automatic rd(input logic [3:0] pg, input logic [7:0] ad, output logic [7:0] d);
		@(negedge clk);
		sfr_page = pg;
		sfr_addr = ad;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Ticks in a 40 cycle window: system path 40/2^div, local path 40/5
	function automatic logic [7:0] exp_ticks(input logic [7:0] c);
		return c[0] ? (8'd40 >> c[6:5]) : 8'd8;
	endfunction

	task report_and_stop;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		report_and_stop;
	end

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [7:0] v, c, a;
		logic [1:0] b;
		int n;
		void'($urandom(10970));
		wait_n(10);
		rstn = 1'b1;
		rd(4'h0, 8'h96, v);
		chk("cfg_reset", v, 8'h00);
		rd(4'hf, 8'h94, v);
		chk("mode_reset", v, 8'h00);
		for (int i = 0; i < 8; i++) begin
			c = (i < 2) ? {8{i[0]}} : 8'($urandom);
			wr(4'h0, 8'h96, c);
			rd(4'h0, 8'h96, v);
			chk("cfg_read", v, c);
			chk("low_power", {7'h0, low_power_enable}, {7'h0, c[7]});
			chk("peak_thr", {7'h0, peak_current_threshold}, {7'h0, c[2]});
		end
		// Unmapped places
		wr(4'h0, 8'h94, 8'hff);
		rd(4'hf, 8'h94, v);
		chk("unmapped_wr", v, 8'h00);
		rd(4'h3, 8'h96, v);
		chk("unmapped_rd", v, 8'h00);
		// Every bypass code
		for (int k = 0; k < 4; k++) begin
			b = 2'(k);
			bypass_active = (b != 2'h1);
			wr(4'hf, 8'h94, {4'hf, 1'b0, b, b[0]});
			wait_n(1);
			rd(4'hf, 8'h94, v);
			chk("mode_read", v, {4'h0, bypass_active, b, b[0]});
			chk("byp_auto", {7'h0, bypass_auto}, {7'h0, b == 2'h1 || b == 2'h2});
			chk("byp_force", {7'h0, bypass_force}, {7'h0, b == 2'h3});
			chk("osc_stop", {7'h0, conv_osc_stop}, {7'h0, b == 2'h2});
			chk("passive", {7'h0, passive_diode_enable}, {7'h0, b[0]});
		end
		// Auto stop code with no bypass in progress
		bypass_active = 1'b0;
		wr(4'hf, 8'h94, 8'h04);
		wait_n(1);
		chk("osc_stop_idle", {7'h0, conv_osc_stop}, 8'h00);
		chk("byp_auto_idle", {7'h0, bypass_auto}, 8'h01);
		// Sleep rail, all combinations
		for (int k = 0; k < 8; k++) begin
			sleep_mode = k[2];
			conv_enable = k[1];
			wr(4'h0, 8'h96, {6'h0, k[0], 1'b0});
			wait_n(2);
			chk("rail_batt", {7'h0, rail_to_battery}, {7'h0, k[2] & k[1] & ~k[0]});
			chk("rail_float", {7'h0, rail_floating}, {7'h0, k[2] & k[1] & k[0]});
		end
		// Converter clock source, divider and inversion
		for (int k = 0; k < 8; k++) begin
			c = {1'b0, 2'(k), 1'b0, 1'($urandom), 2'b00, k[2]};
			wr(4'h0, 8'h96, c);
			wait_n(20);
			n = 0;
			repeat (40) begin
				@(negedge clk);
				n += int'(conv_clk_tick);
			end
			chk("conv_ticks", 8'(n), exp_ticks(c));
			chk("on_fall", {7'h0, conv_clk_on_fall}, {7'h0, c[3] & c[0]});
		end
		// Sampling clock polarity with the phase frozen
		osc_run = 1'b0;
		wr(4'h0, 8'h96, 8'h00);
		for (int s = 1; s >= 0; s--) begin
			conv_sync_enable = s[0];
			wr(4'h0, 8'h96, 8'h10);
			wait_n(10);
			a = {7'h0, adc_sample_clk};
			chk("track", {7'h0, adc_track_enable}, a & {7'h0, s[0]});
			wr(4'h0, 8'h96, 8'h00);
			wait_n(3);
			chk("adc_pol", {7'h0, adc_sample_clk}, a ^ {7'h0, s[0]});
		end
		report_and_stop;
	end
endmodule
